/* hw/psr_pkg.sv */
package psr_pkg;
  localparam int PA_W = 8;
  localparam int PB_W = 6;
  localparam int PIN_W = PA_W + PB_W;

  // Register byte addresses on the APB
  localparam logic [7:0] A_PA_DAT = 8'h00;
  localparam logic [7:0] A_PA_DIR = 8'h04;
  localparam logic [7:0] A_PA_WAKE = 8'h08;
  localparam logic [7:0] A_PB_DAT = 8'h0c;
  localparam logic [7:0] A_PB_DIR = 8'h10;
  localparam logic [7:0] A_PA_FSEL = 8'h14;
  localparam logic [7:0] A_PB_FSEL = 8'h18;
  localparam logic [7:0] A_REMAP = 8'h1c;
  localparam logic [7:0] A_RST_CTRL = 8'h20;

  // Reset values
  localparam logic [7:0] PORT_RST = 8'hff;
  localparam logic [7:0] CLR_RST = 8'h00;
  localparam logic [7:0] RST_CTRL_RST = 8'h00;
  localparam logic [7:0] RST_CTRL_KEY = 8'h55;

  // Implemented-bit masks per variant
  localparam logic [7:0] PA_FSEL_MASK_W = 8'he0;
  localparam logic [7:0] PA_FSEL_MASK_S = 8'h55;
  localparam logic [7:0] PB_FSEL_MASK = 8'h3e;
  localparam logic [7:0] REMAP_MASK_W = 8'hfb;
  localparam logic [7:0] REMAP_MASK_S = 8'h33;
  localparam logic [7:0] PB_MASK = 8'h3f;

  // Remap field positions
  localparam int RM_T1CK_LSB = 6;
  localparam int RM_T0CK = 5;
  localparam int RM_T0CAP = 4;
  localparam int RM_T1CAP = 3;
  localparam int RM_IRQ_LSB = 0;

  // Select bit positions: two-timer port A, single-timer port A, port B
  localparam int SW_A7 = 7;
  localparam int SW_A6 = 6;
  localparam int SW_A4 = 5;
  localparam int SS_A5 = 6;
  localparam int SS_A2 = 4;
  localparam int SS_A1 = 2;
  localparam int SS_A0 = 0;
  localparam int B5 = 5;
  localparam int B4 = 4;
  localparam int B3 = 3;
  localparam int B2 = 2;
  localparam int B1 = 1;
  // Pin positions on port A
  localparam int A7 = 7;
  localparam int A6 = 6;
  localparam int A5 = 5;
  localparam int A4 = 4;
  localparam int A2 = 2;
  localparam int A1 = 1;
  localparam int A0 = 0;

  // Source pin tables, index into {port B, port A}
  typedef logic [3:0] psr_pin_t;
  localparam psr_pin_t T1CK_SRC [4] = '{4'h4, 4'h6, 4'h7, 4'h9};
  localparam psr_pin_t IRQ_SRC_W [4] = '{4'h3, 4'h2, 4'h4, 4'h5};
  localparam psr_pin_t IRQ_SRC_S [4] = '{4'h5, 4'h2, 4'h3, 4'h7};
  localparam psr_pin_t T0CK_SRC_W [2] = '{4'h3, 4'h2};
  localparam psr_pin_t T0CK_SRC_S [2] = '{4'h7, 4'h6};
  localparam psr_pin_t T0CAP_SRC [2] = '{4'h6, 4'h0};
  localparam psr_pin_t T1CAP_SRC [2] = '{4'h5, 4'h8};

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } psr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } psr_apb_rsp_t;

  typedef struct packed {
    logic pwm;
    logic pwm_inv;
  } psr_tmr_out_t;

  typedef struct packed {
    logic t0_clk;
    logic t0_cap;
    logic t1_clk;
    logic t1_cap;
    logic ext_irq;
  } psr_route_t;
endpackage : psr_pkg

/* hw/psr_pin_mux.sv */
`timescale 1ns/1ps
// Summary of operation
// - Two-timer: port A select 7 drives timer0 inverted output, only when key is 55H.
// - Two-timer: port A select 6 puts timer0 primary output on pin A6.
// - Two-timer: port A select 5 puts timer0 primary output on pin A4.
// - Two-timer: port A select bits 4..0 read zero, writes ignored.
// - Port B selects 5..2 drive timer1 outputs: 5,3 primary, 4,2 inverted.
// - Port B select 1 drives timer0 inverted; bits 7,6,0 read zero.
// - Single-timer: timer0 clock from A7 at 0, from A6 at 1.
// - Timer0 capture from A6 at 0, from A0 at 1.
// - Single-timer: interrupt source A5, A2, A3, A7 for codes 00..11.
// - Two-timer: timer1 clock from A4, A6, A7, B1 for codes 00..11.
// - Two-timer: timer0 clock from A3 at 0, from A2 at 1.
// - Two-timer: timer1 capture from A5 at 0, from B0 at 1.
// - Two-timer: interrupt source A3, A2, A4, A5; remap bit 2 reads zero.
// - Single-timer remap bits 7,6,3,2 read zero; selects clear at reset.
// - Data latches and direction bits reset to one; pins start as inputs.
// - A pin turned output without a data write drives high.
// - Bit set and clear are whole-byte read, modify, write back.
// - While asleep, falling edge on wake-enabled port A pin wakes device.
// - Direction 1 reads pin level; direction 0 drives and reads the latch.
// - Port A wake enables arm per pin and clear at reset.
module psr_pin_mux #(
  parameter bit TWO_TMR = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire psr_pkg::psr_apb_req_t apb_req_in,
  output psr_pkg::psr_apb_rsp_t apb_rsp_out,
  input wire logic [psr_pkg::PA_W-1:0] pa_pin_in,
  output logic [psr_pkg::PA_W-1:0] pa_pin_out,
  output logic [psr_pkg::PA_W-1:0] pa_pin_oe_out,
  input wire logic [psr_pkg::PB_W-1:0] pb_pin_in,
  output logic [psr_pkg::PB_W-1:0] pb_pin_out,
  output logic [psr_pkg::PB_W-1:0] pb_pin_oe_out,
  input wire psr_pkg::psr_tmr_out_t timer0_in,
  input wire psr_pkg::psr_tmr_out_t timer1_in,
  output psr_pkg::psr_route_t route_out,
  input wire logic sleep_in,
  output logic wake_out
);
  localparam logic [7:0] FSEL_MASK = TWO_TMR ? psr_pkg::PA_FSEL_MASK_W : psr_pkg::PA_FSEL_MASK_S;
  localparam logic [7:0] PBSEL_MASK = TWO_TMR ? psr_pkg::PB_FSEL_MASK : '0;
  localparam logic [7:0] REMAP_MASK = TWO_TMR ? psr_pkg::REMAP_MASK_W : psr_pkg::REMAP_MASK_S;
  localparam logic [7:0] PB_EXIST = TWO_TMR ? psr_pkg::PB_MASK : '0;

  // Pick one pin level out of the combined port vector
  function automatic logic pin_pick(input logic [psr_pkg::PIN_W-1:0] lv, input psr_pkg::psr_pin_t idx);
    pin_pick = lv[idx];
  endfunction : pin_pick

  logic [7:0] pa_dat_r;
  logic [7:0] pa_dir_r;
  logic [7:0] pa_wake_r;
  logic [7:0] pb_dat_r;
  logic [7:0] pb_dir_r;
  logic [7:0] pa_fsel_r;
  logic [7:0] pb_fsel_r;
  logic [7:0] remap_r;
  logic [7:0] rst_ctrl_r;
  logic [psr_pkg::PIN_W-1:0] s1_r;
  logic [psr_pkg::PIN_W-1:0] s2_r;
  logic [psr_pkg::PIN_W-1:0] s3_r;
  logic [psr_pkg::PIN_W-1:0] lvl_r;
  logic [psr_pkg::PA_W-1:0] pa_prev_r;
  psr_pkg::psr_apb_rsp_t rsp_r;
  psr_pkg::psr_route_t route_r;
  logic [7:0] pa_o_r;
  logic [7:0] pa_oe_r;
  logic [7:0] pb_o_r;
  logic [7:0] pb_oe_r;
  logic wake_r;
  logic wr_en;
  logic setup;
  logic [7:0] rd_val;
  logic rd_hit;
  logic [7:0] pa_lvl;
  logic [7:0] pb_lvl;
  logic [7:0] pa_tsel;
  logic [7:0] pa_tval;
  logic [7:0] pb_tsel;
  logic [7:0] pb_tval;
  logic key_ok;
  logic [7:0] pa_fall;

  assign setup = apb_req_in.psel & ~apb_req_in.penable;
  // Access edge: request held since setup, answer already offered
  assign wr_en = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite & rsp_r.pready;
  assign pa_lvl = lvl_r[psr_pkg::PA_W-1:0];
  assign pb_lvl = {2'b00, lvl_r[psr_pkg::PIN_W-1:psr_pkg::PA_W]} & PB_EXIST;
  assign key_ok = (rst_ctrl_r == psr_pkg::RST_CTRL_KEY);
  assign pa_fall = pa_prev_r & ~pa_lvl;

  // Pin synchroniser: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      lvl_r <= '1;
    end else begin
      s1_r <= {pb_pin_in, pa_pin_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & lvl_r);
    end
  end

  // Port data, direction and wake registers; unimplemented bits are never stored
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pa_dat_r <= psr_pkg::PORT_RST;
      pa_dir_r <= psr_pkg::PORT_RST;
      pb_dat_r <= psr_pkg::PORT_RST & PB_EXIST;
      pb_dir_r <= psr_pkg::PORT_RST & PB_EXIST;
      pa_wake_r <= psr_pkg::CLR_RST;
    end else if (wr_en) begin
      case (apb_req_in.paddr)
        psr_pkg::A_PA_DAT: pa_dat_r <= apb_req_in.pwdata[7:0];
        psr_pkg::A_PA_DIR: pa_dir_r <= apb_req_in.pwdata[7:0];
        psr_pkg::A_PA_WAKE: pa_wake_r <= apb_req_in.pwdata[7:0];
        psr_pkg::A_PB_DAT: pb_dat_r <= apb_req_in.pwdata[7:0] & PB_EXIST;
        psr_pkg::A_PB_DIR: pb_dir_r <= apb_req_in.pwdata[7:0] & PB_EXIST;
        default: ;
      endcase
    end
  end

  // Function select, remap and reset-control key registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pa_fsel_r <= psr_pkg::CLR_RST;
      pb_fsel_r <= psr_pkg::CLR_RST;
      remap_r <= psr_pkg::CLR_RST;
      rst_ctrl_r <= psr_pkg::RST_CTRL_RST;
    end else if (wr_en) begin
      case (apb_req_in.paddr)
        psr_pkg::A_PA_FSEL: pa_fsel_r <= apb_req_in.pwdata[7:0] & FSEL_MASK;
        psr_pkg::A_PB_FSEL: pb_fsel_r <= apb_req_in.pwdata[7:0] & PBSEL_MASK;
        psr_pkg::A_REMAP: remap_r <= apb_req_in.pwdata[7:0] & REMAP_MASK;
        psr_pkg::A_RST_CTRL: rst_ctrl_r <= apb_req_in.pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read mux; an output pin reads its latch so bit set/clear never copies pin loading back
  always_comb begin
    rd_hit = 1'b1;
    case (apb_req_in.paddr)
      psr_pkg::A_PA_DAT: rd_val = (pa_dir_r & pa_lvl) | (~pa_dir_r & pa_dat_r);
      psr_pkg::A_PA_DIR: rd_val = pa_dir_r;
      psr_pkg::A_PA_WAKE: rd_val = pa_wake_r;
      psr_pkg::A_PB_DAT: rd_val = (pb_dir_r & pb_lvl) | (~pb_dir_r & pb_dat_r);
      psr_pkg::A_PB_DIR: rd_val = pb_dir_r;
      psr_pkg::A_PA_FSEL: rd_val = pa_fsel_r;
      psr_pkg::A_PB_FSEL: rd_val = pb_fsel_r;
      psr_pkg::A_REMAP: rd_val = remap_r;
      psr_pkg::A_RST_CTRL: rd_val = rst_ctrl_r;
      default: begin
        rd_val = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // APB answer: ready in the first access cycle, data captured at setup
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_r <= '0;
    end else begin
      rsp_r.pready <= setup;
      if (setup) begin
        rsp_r.prdata <= {24'h000000, rd_val};
        rsp_r.pslverr <= ~rd_hit;
      end
    end
  end

  // Which pins carry a timer output, and which output
  always_comb begin
    pa_tsel = '0;
    pa_tval = '0;
    pb_tsel = '0;
    pb_tval = '0;
    if (TWO_TMR) begin
      pa_tsel[psr_pkg::A7] = pa_fsel_r[psr_pkg::SW_A7] & key_ok;
      pa_tval[psr_pkg::A7] = timer0_in.pwm_inv;
      pa_tsel[psr_pkg::A6] = pa_fsel_r[psr_pkg::SW_A6];
      pa_tval[psr_pkg::A6] = timer0_in.pwm;
      pa_tsel[psr_pkg::A4] = pa_fsel_r[psr_pkg::SW_A4];
      pa_tval[psr_pkg::A4] = timer0_in.pwm;
      pb_tsel = pb_fsel_r;
      pb_tval[psr_pkg::B5] = timer1_in.pwm;
      pb_tval[psr_pkg::B4] = timer1_in.pwm_inv;
      pb_tval[psr_pkg::B3] = timer1_in.pwm;
      pb_tval[psr_pkg::B2] = timer1_in.pwm_inv;
      pb_tval[psr_pkg::B1] = timer0_in.pwm_inv;
    end else begin
      pa_tsel[psr_pkg::A5] = pa_fsel_r[psr_pkg::SS_A5];
      pa_tval[psr_pkg::A5] = timer0_in.pwm_inv;
      pa_tsel[psr_pkg::A2] = pa_fsel_r[psr_pkg::SS_A2];
      pa_tval[psr_pkg::A2] = timer0_in.pwm;
      pa_tsel[psr_pkg::A1] = pa_fsel_r[psr_pkg::SS_A1];
      pa_tval[psr_pkg::A1] = timer0_in.pwm_inv;
      pa_tsel[psr_pkg::A0] = pa_fsel_r[psr_pkg::SS_A0];
      pa_tval[psr_pkg::A0] = timer0_in.pwm;
    end
  end

  // Pin drivers: timer output replaces the latch; a timer pin is always driven
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pa_o_r <= '0;
      pa_oe_r <= '0;
      pb_o_r <= '0;
      pb_oe_r <= '0;
    end else begin
      pa_o_r <= (pa_tsel & pa_tval) | (~pa_tsel & pa_dat_r);
      pa_oe_r <= pa_tsel | ~pa_dir_r;
      pb_o_r <= ((pb_tsel & pb_tval) | (~pb_tsel & pb_dat_r)) & PB_EXIST;
      pb_oe_r <= (pb_tsel | ~pb_dir_r) & PB_EXIST;
    end
  end

  // Remapped timer and interrupt inputs, each taken from its one chosen pin, except timer1 clock and capture, held low in single-timer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      route_r <= '0;
    end else begin
      route_r.t0_cap <= pin_pick(lvl_r, psr_pkg::T0CAP_SRC[remap_r[psr_pkg::RM_T0CAP]]);
      if (TWO_TMR) begin
        route_r.t0_clk <= pin_pick(lvl_r, psr_pkg::T0CK_SRC_W[remap_r[psr_pkg::RM_T0CK]]);
        route_r.t1_clk <= pin_pick(lvl_r, psr_pkg::T1CK_SRC[remap_r[psr_pkg::RM_T1CK_LSB +: 2]]);
        route_r.t1_cap <= pin_pick(lvl_r, psr_pkg::T1CAP_SRC[remap_r[psr_pkg::RM_T1CAP]]);
        route_r.ext_irq <= pin_pick(lvl_r, psr_pkg::IRQ_SRC_W[remap_r[psr_pkg::RM_IRQ_LSB +: 2]]);
      end else begin
        route_r.t0_clk <= pin_pick(lvl_r, psr_pkg::T0CK_SRC_S[remap_r[psr_pkg::RM_T0CK]]);
        route_r.t1_clk <= 1'b0;
        route_r.t1_cap <= 1'b0;
        route_r.ext_irq <= pin_pick(lvl_r, psr_pkg::IRQ_SRC_S[remap_r[psr_pkg::RM_IRQ_LSB +: 2]]);
      end
    end
  end

  // Wake pulse on a filtered falling edge; filtering keeps pin glitches from waking
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pa_prev_r <= '1;
      wake_r <= 1'b0;
    end else begin
      pa_prev_r <= pa_lvl;
      wake_r <= sleep_in & |(pa_fall & pa_wake_r);
    end
  end

  assign apb_rsp_out = rsp_r;
  assign pa_pin_out = pa_o_r;
  assign pa_pin_oe_out = pa_oe_r;
  assign pb_pin_out = pb_o_r[psr_pkg::PB_W-1:0];
  assign pb_pin_oe_out = pb_oe_r[psr_pkg::PB_W-1:0];
  assign route_out = route_r;
  assign wake_out = wake_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_pa7_key_gate: assert property (TWO_TMR && pa_fsel_r[psr_pkg::SW_A7] && !key_ok && pa_dir_r[psr_pkg::A7]
    |=> !pa_oe_r[psr_pkg::A7]) else $error("pin A7 driven without key");
  chk_pa6_timer_out: assert property (TWO_TMR && pa_fsel_r[psr_pkg::SW_A6]
    |=> pa_o_r[psr_pkg::A6] == $past(timer0_in.pwm) && pa_oe_r[psr_pkg::A6])
    else $error("pin A6 not on timer0 output");
  chk_pa4_timer_out: assert property (TWO_TMR && pa_fsel_r[psr_pkg::SW_A4]
    |=> pa_o_r[psr_pkg::A4] == $past(timer0_in.pwm)) else $error("pin A4 not on timer0 output");
  chk_fsel_unused: assert property ((pa_fsel_r & ~FSEL_MASK) == '0 && (pb_fsel_r & ~PBSEL_MASK) == '0)
    else $error("unimplemented select bit set");
  chk_pb4_inverted: assert property (TWO_TMR && pb_fsel_r[psr_pkg::B4]
    |=> pb_o_r[psr_pkg::B4] == $past(timer1_in.pwm_inv)) else $error("pin B4 not on timer1 inverted");
  chk_remap_unused: assert property ((remap_r & ~REMAP_MASK) == '0) else $error("reserved remap bit set");
  chk_latch_drive: assert property (!pa_tsel[psr_pkg::A0] && !pa_dir_r[psr_pkg::A0]
    |=> pa_o_r[psr_pkg::A0] == $past(pa_dat_r[psr_pkg::A0]) && pa_oe_r[psr_pkg::A0])
    else $error("output pin not driven from latch");
  chk_wake_fall: assert property (sleep_in && |(pa_fall & pa_wake_r) |=> wake_r)
    else $error("wake not raised on falling edge");
  chk_wake_awake: assert property (!sleep_in |=> !wake_r) else $error("wake raised while awake");
  // Armed one edge after reset release, so the reset-held route value is never compared
  chk_capture_route: assert property (rst_n_in |=> route_r.t0_cap == $past(remap_r[psr_pkg::RM_T0CAP] ?
    lvl_r[psr_pkg::A0] : lvl_r[psr_pkg::A6])) else $error("capture input misrouted");
endmodule : psr_pin_mux

/* tb/psr_pin_model.sv */
`timescale 1ns/1ps
// Pad model: a driven pin shows the block's value, a released pin the board level
module psr_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] drv_in,
  input wire logic [W-1:0] oe_in,
  input wire logic [W-1:0] board_in,
  output logic [W-1:0] pad_out
);
  // Per-pin resolve; board level stands in for the pull-ups when released
  assign pad_out = (oe_in & drv_in) | (~oe_in & board_in);
endmodule : psr_pin_model

/* tb/port_pin_share_remap_tb_top.sv */
`timescale 1ns/1ps
module port_pin_share_remap_tb_top;
  logic clk_in, rst_n_in, sleep, err;
  psr_pkg::psr_apb_req_t req;
  psr_pkg::psr_apb_rsp_t rsp, rsp2;
  psr_pkg::psr_tmr_out_t t0, t1;
  psr_pkg::psr_route_t route, route2;
  logic [7:0] pa_out, pa_oe, pa_in, pa_ext;
  logic [5:0] pb_out, pb_oe, pb_in, pb_ext;
  logic wake;
  logic [31:0] rd, rd2;
  logic [15:0] e;
  int miscompares = 0, n_tests = 0, wakes = 0;
  // Remap byte, source pin (8 and up is port B), route bit
  localparam logic [15:0] RM_TAB [14] = '{16'h0042, 16'h4062, 16'h8072, 16'hc092, 16'h0034, 16'h2024,
    16'h0063, 16'h1003, 16'h0051, 16'h0881, 16'h0030, 16'h0120, 16'h0240, 16'h0350};
  // Same layout for the single-timer variant
  localparam logic [15:0] RM_TAB_S [8] = '{16'h0074, 16'h2064, 16'h0063, 16'h1003, 16'h0050, 16'h0120,
    16'h0230, 16'h0370};
  localparam logic [7:0] RST_A [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  localparam logic [7:0] RST_V [9] = '{8'hff, 8'hff, 8'h00, 8'h3f, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00};

  psr_pin_mux psr_pin_mux_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .apb_req_in(req), .apb_rsp_out(rsp),
    .pa_pin_in(pa_in), .pa_pin_out(pa_out), .pa_pin_oe_out(pa_oe), .pb_pin_in(pb_in), .pb_pin_out(pb_out),
    .pb_pin_oe_out(pb_oe), .timer0_in(t0), .timer1_in(t1), .route_out(route), .sleep_in(sleep),
    .wake_out(wake));
  // Single-timer variant on the same bus; its pins see the board levels only
  psr_pin_mux #(.TWO_TMR(1'b0)) psr_pin_mux_inst_s (.clk_in(clk_in), .rst_n_in(rst_n_in), .apb_req_in(req),
    .apb_rsp_out(rsp2), .pa_pin_in(pa_ext), .pa_pin_out(), .pa_pin_oe_out(), .pb_pin_in(pb_ext),
    .pb_pin_out(), .pb_pin_oe_out(), .timer0_in(t0), .timer1_in(t1), .route_out(route2), .sleep_in(sleep),
    .wake_out());
  psr_pin_model #(.W(8)) psr_pin_model_inst (.drv_in(pa_out), .oe_in(pa_oe), .board_in(pa_ext),
    .pad_out(pa_in));
  psr_pin_model #(.W(6)) psr_pin_model_inst_b (.drv_in(pb_out), .oe_in(pb_oe), .board_in(pb_ext),
    .pad_out(pb_in));

  // Clock, 40 ns period
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Wake pulses counted as seen at each edge
  always @(posedge clk_in) begin
    if (wake === 1'b1) wakes <= wakes + 1;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
  endtask : settle

  // One APB transfer; request held until pready is seen, then one idle edge before the next setup
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= {24'h0, wd};
    @(posedge clk_in);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    rd2 = rsp2.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    // Zero wait states: ready at the first access edge
    chk(n, 1);
    @(posedge clk_in);
    // Ready is a one-cycle pulse
    chk({31'h0, rsp.pready}, 32'h0);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, exp});
    chk({31'h0, err}, 32'h0);
  endtask : rdc

  // Watchdog, far beyond the roughly 590 cycles the tests take
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    summarize();
  end

  initial begin
    rst_n_in = 1'b0;
    req = '0;
    t0 = '{pwm: 1'b0, pwm_inv: 1'b1};
    t1 = '{pwm: 1'b1, pwm_inv: 1'b0};
    sleep = 1'b0;
    pa_ext = 8'hff;
    pb_ext = 6'h3f;
    settle(20);
    rst_n_in <= 1'b1;
    settle(2);
    // Reset values and released pins
    for (int i = 0; i < 9; i++) rdc(RST_A[i], RST_V[i]);
    chk({16'h0, pa_oe, pa_out}, {16'h0, 8'h00, 8'hff});
    apb(1'b0, 8'h24, 8'h00);
    chk({rd[30:0], err}, 32'h1);
    // Unimplemented bits read zero
    wr(8'h14, 8'hff);
    rdc(8'h14, 8'he0);
    wr(8'h18, 8'hff);
    rdc(8'h18, 8'h3e);
    wr(8'h1c, 8'hff);
    rdc(8'h1c, 8'hfb);
    chk(rd2, 32'h33);
    wr(8'h1c, 8'h00);
    // Timer outputs on ports A and B; bit 7 locked until the key is written
    settle(2);
    chk({16'h0, pa_oe, pa_out}, {16'h0, 8'h50, 8'haf});
    wr(8'h20, 8'h55);
    t0 <= '{pwm: 1'b1, pwm_inv: 1'b0};
    settle(3);
    chk({16'h0, pa_oe, pa_out}, {16'h0, 8'hd0, 8'h7f});
    chk({20'h0, pb_oe, pb_out}, {20'h0, 6'h3e, 6'h29});
    wr(8'h14, 8'h00);
    wr(8'h18, 8'h00);
    wr(8'h20, 8'h00);
    // Output with untouched latch drives high; output read returns latch
    pa_ext <= 8'h00;
    wr(8'h04, 8'h00);
    settle(2);
    chk({16'h0, pa_oe, pa_out}, {16'h0, 8'hff, 8'hff});
    wr(8'h00, 8'h5b);
    settle(2);
    chk({24'h0, pa_out}, 32'h5b);
    rdc(8'h00, 8'h5b);
    // Bit set on direction done as read, modify, write back
    apb(1'b0, 8'h04, 8'h00);
    wr(8'h04, rd[7:0] | 8'h01);
    settle(8);
    rdc(8'h00, 8'h5a);
    pa_ext <= 8'hff;
    wr(8'h04, 8'hff);
    // Each remap code routes only its chosen pin
    foreach (RM_TAB[i]) begin
      e = RM_TAB[i];
      wr(8'h1c, e[15:8]);
      {pb_ext, pa_ext} <= ~(14'h1 << e[7:4]);
      settle(8);
      chk({31'h0, route[e[3:0]]}, 32'h0);
      {pb_ext, pa_ext} <= 14'h3fff;
      settle(8);
      chk({31'h0, route[e[3:0]]}, 32'h1);
    end
    // Single-timer remap codes on the second instance
    foreach (RM_TAB_S[i]) begin
      e = RM_TAB_S[i];
      wr(8'h1c, e[15:8]);
      {pb_ext, pa_ext} <= ~(14'h1 << e[7:4]);
      settle(8);
      chk({31'h0, route2[e[3:0]]}, 32'h0);
      {pb_ext, pa_ext} <= 14'h3fff;
      settle(8);
      chk({31'h0, route2[e[3:0]]}, 32'h1);
    end
    // Wake on a fall only while asleep, only from an armed pin
    wr(8'h08, 8'h08);
    rdc(8'h08, 8'h08);
    sleep <= 1'b1;
    pa_ext <= 8'hf7;
    settle(10);
    chk(wakes, 1);
    pa_ext <= 8'hf3;
    settle(10);
    chk(wakes, 1);
    pa_ext <= 8'hff;
    sleep <= 1'b0;
    settle(10);
    pa_ext <= 8'hf7;
    settle(10);
    chk(wakes, 1);
    summarize();
  end
endmodule : port_pin_share_remap_tb_top
